// [verilog/pdrc_top.v]
// Purpose: Power-down and reset sequencing with APB control registers
// Assumes: pclk stands for the master clock; pins are asynchronous
// Notes: Analog and canceller blocks sit outside; they obey the clear and enable outputs
// Notes: A single-cycle pin pulse is filtered by the synchronisers
`timescale 1ns/1ps
`include "pdrc_defs.vh"

module pdrc_top #(
  parameter [31:0] SYNC_IDLE_CYC = `PDRC_SYNC_IDLE_DEF
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire powerdown_reset_n,
  input wire line_codec_powerdown_in,
  input wire frame_sync_in,
  output reg clear_state,
  output reg initial_mode,
  output reg line_codec_enable,
  output reg acoustic_out_oe,
  output reg line_out_oe,
  output reg level_adjust_oe,
  output reg sync_powerdown,
  output reg sync_powerdown_mode_select
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  reg [2:0] rst_sync_q;
  reg [2:0] line_sync_q;
  reg [2:0] fs_sync_q;
  reg rst_pin_n_q;
  reg line_pin_q;
  reg fs_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_sync_q <= 3'h0;
      line_sync_q <= 3'h0;
      fs_sync_q <= 3'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[1:0], powerdown_reset_n};
      line_sync_q <= {line_sync_q[1:0], line_codec_powerdown_in};
      fs_sync_q <= {fs_sync_q[1:0], frame_sync_in};
    end
  end

  // One extra cycle of latency; a single-cycle glitch never gets through
  // Accept a change only when stages two and three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_pin_n_q <= 1'b0;
      line_pin_q <= 1'b0;
      fs_q <= 1'b0;
    end else begin
      if (rst_sync_q[1] == rst_sync_q[2])
        rst_pin_n_q <= rst_sync_q[2];
      if (line_sync_q[1] == line_sync_q[2])
        line_pin_q <= line_sync_q[2];
      if (fs_sync_q[1] == fs_sync_q[2])
        fs_q <= fs_sync_q[2];
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  reg [7:0] ctrl0_q;
  reg [7:0] ctrl11_q;
  wire ctrl0_soft_powerdown_bit;
  wire ctrl0_line_powerdown_bit;
  wire ctrl11_powerdown_mode_bit;
  wire pd_reset;
  wire wr_en;
  wire [2:0] reg_sel;
  wire sel_ctrl0;
  wire sel_ctrl11;
  wire sel_status;

  // Register select decode, shared by the write and error paths; the read mux decodes paddr itself
  function [2:0] pdrc_reg_sel;
    input [11:0] addr;
    begin
      case (addr)
        `PDRC_OFF_CTRL0: pdrc_reg_sel = 3'h1;
        `PDRC_OFF_CTRL11: pdrc_reg_sel = 3'h2;
        `PDRC_OFF_STATUS: pdrc_reg_sel = 3'h4;
        default: pdrc_reg_sel = 3'h0;
      endcase
    end
  endfunction

  // One-hot view of the addressed register
  assign reg_sel = pdrc_reg_sel(paddr);
  assign sel_ctrl0 = reg_sel[0];
  assign sel_ctrl11 = reg_sel[1];
  assign sel_status = reg_sel[2];

  // Field views of the control registers
  assign ctrl0_soft_powerdown_bit = ctrl0_q[`PDRC_CTRL0_SOFT_PD];
  assign ctrl0_line_powerdown_bit = ctrl0_q[`PDRC_CTRL0_LINE_PD];
  assign ctrl11_powerdown_mode_bit = ctrl11_q[`PDRC_CTRL11_MODE];

  // Either source alone holds the sequencer in reset
  // negative-logic OR of pin and soft bit
  assign pd_reset = ~rst_pin_n_q | ctrl0_soft_powerdown_bit;
  assign wr_en = psel & penable & pwrite;

  // Register writes; the pin reset clears everything
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_q <= `PDRC_CTRL0_RST;
      ctrl11_q <= `PDRC_CTRL11_RST;
    end else if (~rst_pin_n_q) begin
      ctrl0_q <= `PDRC_CTRL0_RST;
      ctrl11_q <= `PDRC_CTRL11_RST;
    end else if (ctrl0_soft_powerdown_bit && !(wr_en && sel_ctrl0)) begin
      // Soft reset clears all but its own bit until software drops it
      ctrl0_q <= 8'h80;
      ctrl11_q <= `PDRC_CTRL11_RST;
    end else if (wr_en) begin
      if (sel_ctrl0)
        ctrl0_q <= pwdata[7:0];
      // Control-11 writes are refused while the soft reset bit is held
      if (sel_ctrl11 && !ctrl0_soft_powerdown_bit)
        ctrl11_q <= pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Frame sync activity watch
  // ---------------------------------------------------------------
  reg fs_prev_q;
  reg [31:0] idle_cnt_q;
  wire fs_edge;
  wire fs_stuck;

  // Edge of the synced sync; the counter saturates so a long stop never wraps
  assign fs_edge = fs_q ^ fs_prev_q;
  assign fs_stuck = (idle_cnt_q >= SYNC_IDLE_CYC);

  // count cycles without a sync edge
  // frame sync sampled on master clock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_prev_q <= 1'b0;
      idle_cnt_q <= 32'h0;
    end else begin
      fs_prev_q <= fs_q;
      if (fs_edge || pd_reset)
        idle_cnt_q <= 32'h0;
      else if (!fs_stuck)
        idle_cnt_q <= idle_cnt_q + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // Reset sequencer
  // ---------------------------------------------------------------
  // Reset, then a fixed-length initial mode, then normal running
  localparam ST_RESET = 2'd0;
  localparam ST_INIT = 2'd1;
  localparam ST_RUN = 2'd2;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [15:0] init_cnt_q;
  wire init_done;

  // Widened compare keeps the full count constant; a reset cuts the mode short
  assign init_done = ({16'h0, init_cnt_q} == `PDRC_INIT_CYC - 1);

  // Next state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RESET: begin
        if (!pd_reset)
          state_d = ST_INIT;
      end
      ST_INIT: begin
        if (pd_reset)
          state_d = ST_RESET;
        else if (init_done)
          state_d = ST_RUN;
      end
      ST_RUN: begin
        if (pd_reset)
          state_d = ST_RESET;
      end
      default: state_d = ST_RESET;
    endcase
  end

  // State and init counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_RESET;
      init_cnt_q <= 16'h0;
    end else begin
      state_q <= state_d;
      if (state_q == ST_INIT)
        init_cnt_q <= init_cnt_q + 16'h1;
      else
        init_cnt_q <= 16'h0;
    end
  end

  // ---------------------------------------------------------------
  // Control outputs
  // ---------------------------------------------------------------
  wire line_pd_eff;
  wire in_reset;

  assign line_pd_eff = line_pin_q | ctrl0_line_powerdown_bit;
  // Next-state look-ahead, so outputs move with the state register
  assign in_reset = (state_d == ST_RESET);

  // Registered enables for outside blocks
  // Flip-flop outputs so outside blocks never see a decode glitch
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_state <= 1'b1;
      initial_mode <= 1'b0;
      line_codec_enable <= 1'b0;
      acoustic_out_oe <= 1'b0;
      line_out_oe <= 1'b0;
      level_adjust_oe <= 1'b0;
      sync_powerdown <= 1'b0;
      sync_powerdown_mode_select <= 1'b0;
    end else begin
      clear_state <= in_reset;
      initial_mode <= (state_d == ST_INIT);
      line_codec_enable <= ~in_reset & ~line_pd_eff;
      acoustic_out_oe <= ~in_reset & ~fs_stuck;
      level_adjust_oe <= ~in_reset;
      // line outputs off when codec down
      line_out_oe <= ~in_reset & ~line_pd_eff & ~fs_stuck;
      // stuck sync powers down, mode from ctrl11
      sync_powerdown <= fs_stuck & ~in_reset;
      sync_powerdown_mode_select <= ctrl11_powerdown_mode_bit;
    end
  end

  // ---------------------------------------------------------------
  // APB read side
  // ---------------------------------------------------------------
  reg [31:0] rdata_q;
  wire addr_ok;

  // Zero wait states; an unmapped address answers with an error and reads zero
  assign addr_ok = sel_ctrl0 | sel_ctrl11 | sel_status;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = rdata_q;

  // Read mux registered in setup phase
  // Status packs sync stuck, line requests, pin reset and state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `PDRC_OFF_CTRL0: rdata_q <= {24'h0, ctrl0_q};
        `PDRC_OFF_CTRL11: rdata_q <= {24'h0, ctrl11_q};
        `PDRC_OFF_STATUS: rdata_q <= {26'h0, fs_stuck, line_pd_eff, line_pin_q,
                                      ~rst_pin_n_q, state_q};
        default: rdata_q <= 32'h0;
      endcase
    end
  end

endmodule // pdrc_top

// [verilog/pdrc_defs.vh]
// Purpose: Constants for the power-down and reset control block
// Assumes: 32-bit APB, word-aligned registers
// Notes: Offsets are byte addresses
`ifndef PDRC_DEFS_VH
`define PDRC_DEFS_VH
`define PDRC_OFF_CTRL0 12'h000
`define PDRC_OFF_CTRL11 12'h02c
`define PDRC_OFF_STATUS 12'h040
`define PDRC_CTRL0_LINE_PD 5
`define PDRC_CTRL0_SOFT_PD 7
`define PDRC_CTRL11_MODE 0
`define PDRC_CTRL0_RST 8'h00
`define PDRC_CTRL11_RST 8'h00
`define PDRC_INIT_NS 1000
`define PDRC_CLK_PERIOD_PS 5000
`define PDRC_INIT_CYC ((`PDRC_INIT_NS * 1000 + `PDRC_CLK_PERIOD_PS - 1) / `PDRC_CLK_PERIOD_PS)
`define PDRC_SYNC_IDLE_DEF 32'd40000
`endif

// [bench/pdrc_sva.sv]
// Purpose: Port assertions for pdrc_top
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Pin paths settle within seven cycles
`timescale 1ns/1ps
`include "pdrc_defs.vh"
module pdrc_sva (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire powerdown_reset_n,
  input wire line_codec_powerdown_in,
  input wire clear_state,
  input wire initial_mode,
  input wire line_codec_enable,
  input wire acoustic_out_oe,
  input wire line_out_oe,
  input wire level_adjust_oe,
  input wire sync_powerdown,
  input wire sync_powerdown_mode_select
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Length of the running initial-mode stretch
  int init_len_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_len_q <= 0;
    end else if (initial_mode) begin
      init_len_q <= init_len_q + 1;
    end else begin
      init_len_q <= 0;
    end
  end
  init_length_a: assert property ($fell(initial_mode) && !clear_state |->
    init_len_q == `PDRC_INIT_CYC) else $error("initial mode length wrong");
  sync_delay_a: assert property ($fell(powerdown_reset_n) && !clear_state |->
    !clear_state [*5]) else $error("pin reset acted before the synchroniser");
  // Bus answers and pin effects
  ready_high_a: assert property (pready) else $error("pready low");
  unmapped_err_a: assert property (psel && penable && paddr != 12'h000 && paddr != 12'h02c
    && paddr != 12'h040 |-> pslverr) else $error("missing slave error");
  pin_reset_a: assert property (!powerdown_reset_n [*7] |-> clear_state)
    else $error("pin low without reset");
  reset_tristate_a: assert property (clear_state |-> !acoustic_out_oe && !line_out_oe
    && !level_adjust_oe) else $error("outputs driven in reset");
  line_tristate_a: assert property (!line_codec_enable |-> !line_out_oe)
    else $error("line output driven while off");
  line_pin_a: assert property (line_codec_powerdown_in [*7] |-> !line_codec_enable)
    else $error("line codec still on");
  init_entry_a: assert property ($fell(clear_state) |-> ##[0:1] initial_mode [*8])
    else $error("no initial mode after release");
  sync_gate_a: assert property (sync_powerdown && $past(sync_powerdown) |->
    !acoustic_out_oe && !line_out_oe) else $error("outputs on in sync power-down");
  reset_clear_a: assert property (clear_state && $past(clear_state, 2) |->
    !sync_powerdown_mode_select && !sync_powerdown) else $error("state kept in reset");
  cover property ($fell(clear_state));
  cover property ($rose(sync_powerdown));
  cover property ($fell(line_codec_enable));
  cover property ($fell(initial_mode) && !clear_state);
endmodule // pdrc_sva
bind pdrc_top pdrc_sva u_sva (.*);

// [bench/pdrc_host_model.sv]
// Purpose: Host driving the reset, line power-down and frame sync pins
// Assumes: Commands come from the bench
// Notes: A line pin change is followed by a reset pulse
`timescale 1ns/1ps
module pdrc_host_model #(parameter int HALF = 8) (
  input wire logic pclk,
  input wire logic hold_rst,
  input wire logic line_pd,
  input wire logic sync_run,
  output logic powerdown_reset_n,
  output logic line_codec_powerdown_in,
  output logic frame_sync_in
);
  logic [3:0] cnt_q = 4'h0;
  logic [3:0] rst_q = 4'h0;
  initial begin
    powerdown_reset_n = 1'b1;
    line_codec_powerdown_in = 1'b0;
    frame_sync_in = 1'b0;
  end
  // pin high unless resetting, reset after line change
  always @(posedge pclk) begin
    line_codec_powerdown_in <= line_pd;
    rst_q <= (line_pd != line_codec_powerdown_in) ? 4'hc : rst_q - (rst_q != 4'h0);
    powerdown_reset_n <= !(hold_rst || rst_q != 4'h0);
    cnt_q <= (cnt_q == HALF - 1) ? 4'h0 : cnt_q + 4'h1;
    if (sync_run && cnt_q == HALF - 1) begin
      frame_sync_in <= !frame_sync_in;
    end
  end
endmodule // pdrc_host_model

// [bench/powerdown_reset_control_bench.sv]
// Purpose: Self-checking bench for pdrc_top
// Assumes: Host model drives the pins, bench speaks APB
// Notes: Idle limit shortened to 50 cycles
`timescale 1ns/1ps
`include "pdrc_defs.vh"
module powerdown_reset_control_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r, v;
  logic pready, pslverr, err_q, pdn_n, line_in, fs;
  logic hold_rst = 1'b0, line_pd = 1'b0, sync_run = 1'b1;
  logic cs, im, lce, aoe, loe, laoe, spd, sms;
  int bad_count = 0, compares = 0;
  initial forever #2.5 pclk = !pclk;
  pdrc_top #(.SYNC_IDLE_CYC(32'd50)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .powerdown_reset_n(pdn_n),
    .line_codec_powerdown_in(line_in), .frame_sync_in(fs), .clear_state(cs),
    .initial_mode(im), .line_codec_enable(lce), .acoustic_out_oe(aoe), .line_out_oe(loe),
    .level_adjust_oe(laoe), .sync_powerdown(spd), .sync_powerdown_mode_select(sms));
  pdrc_host_model u_host (.pclk(pclk), .hold_rst(hold_rst), .line_pd(line_pd),
    .sync_run(sync_run), .powerdown_reset_n(pdn_n), .line_codec_powerdown_in(line_in),
    .frame_sync_in(fs));
  task automatic finish_test;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // APB transfer; waits for pready, only the watchdog ends a hung wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask
  initial begin
    #100us;
    bad_count++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h0e4c));
    wt(3);
    presetn <= 1'b1;
    wt(`PDRC_INIT_CYC + 50);
    rd(`PDRC_OFF_CTRL0, 32'h0);
    rd(`PDRC_OFF_STATUS, 32'h2);
    rd(12'h010, 32'h0);
    chk(err_q, 32'h1);
    $display("test reset_values done");
    for (int i = 0; i < 6; i++) begin
      v = $urandom;
      apb(1'b1, `PDRC_OFF_CTRL0, v & 32'hffffff20);
      apb(1'b1, `PDRC_OFF_CTRL11, v & 32'hffffff01);
      wt(4);
      rd(`PDRC_OFF_CTRL0, v & 32'h20);
      rd(`PDRC_OFF_CTRL11, v & 32'h1);
      rd(`PDRC_OFF_STATUS, 32'h2 | ((v & 32'h20) >> 1));
      chk({lce, loe}, {2{!v[5]}});
      chk(sms, v[0]);
    end
    $display("test random_regs done");
    apb(1'b1, `PDRC_OFF_CTRL0, 32'ha0);
    wt(3);
    chk({cs, aoe, loe, laoe}, 32'h8);
    rd(`PDRC_OFF_CTRL0, 32'h80);
    apb(1'b1, `PDRC_OFF_CTRL11, 32'h1);
    rd(`PDRC_OFF_CTRL11, 32'h0);
    apb(1'b1, `PDRC_OFF_CTRL0, 32'h0);
    wt(3);
    chk(im, 32'h1);
    wt(`PDRC_INIT_CYC + 50);
    chk({aoe, lce}, 32'h3);
    $display("test soft_reset done");
    hold_rst <= 1'b1;
    wt(1);
    hold_rst <= 1'b0;
    wt(10);
    chk(cs, 32'h0);
    rd(`PDRC_OFF_STATUS, 32'h2);
    $display("test pin_glitch done");
    apb(1'b1, `PDRC_OFF_CTRL11, 32'h1);
    hold_rst <= 1'b1;
    wt(10);
    chk({cs, aoe, loe, laoe}, 32'h8);
    rd(`PDRC_OFF_CTRL11, 32'h0);
    rd(`PDRC_OFF_STATUS, 32'h4);
    hold_rst <= 1'b0;
    wt(`PDRC_INIT_CYC + 50);
    $display("test pin_reset done");
    line_pd <= 1'b1;
    wt(`PDRC_INIT_CYC + 80);
    chk({lce, loe, aoe}, 32'h1);
    rd(`PDRC_OFF_STATUS, 32'h1a);
    line_pd <= 1'b0;
    wt(`PDRC_INIT_CYC + 80);
    chk(lce, 32'h1);
    $display("test line_pin done");
    sync_run <= 1'b0;
    wt(70);
    chk({spd, aoe}, 32'h2);
    rd(`PDRC_OFF_STATUS, 32'h22);
    sync_run <= 1'b1;
    wt(30);
    chk({spd, aoe}, 32'h1);
    $display("test sync_stop done");
    finish_test();
  end
endmodule // powerdown_reset_control_bench
